// ===== rtl/imd_params.svh
/*
 Register map, field positions, reset values and carrier constants of the
 interpolating modulation datapath.
 Assumes inclusion by bare name from the carrier and the datapath files.
*/
`ifndef IMD_PARAMS_SVH
`define IMD_PARAMS_SVH

// Register indices and APB byte addresses
`define IMD_CTRL_IDX      10'h001
`define IMD_STATUS_IDX    10'h01F
`define IMD_CTRL_ADDR     {`IMD_CTRL_IDX, 2'b00}
`define IMD_STATUS_ADDR   {`IMD_STATUS_IDX, 2'b00}

// Control register fields
`define IMD_F_INTERP_HI   7
`define IMD_F_INTERP_LO   6
`define IMD_F_MOD_HI      5
`define IMD_F_MOD_LO      4
`define IMD_F_STUFF       3
`define IMD_F_CPLX        2
`define IMD_F_ROTPOS      1
`define IMD_CTRL_RESET    8'h00

// Status register fields
`define IMD_S_UNDERRUN    0
`define IMD_S_PHASE_LO    1
`define IMD_S_SLOT_LO     4
`define IMD_S_CPLX_ACT    8

// Samples and carrier values, carrier in Q2.14
`define IMD_MIDSCALE      16'h8000
`define IMD_CAR_ONE       16'h4000
`define IMD_CAR_R2        16'h2D41
`define IMD_CAR_FRAC      14

`endif

// ===== rtl/imd_pkg.sv
/*
 Types shared by the interpolating modulation datapath files.
 Assumes imd_params.svh is on the include path.
*/
package imd_pkg;

   typedef enum logic [1:0] {
      IMD_INTERP_1X,
      IMD_INTERP_2X,
      IMD_INTERP_4X,
      IMD_INTERP_8X
   } imd_interp_e_t;

   typedef enum logic [1:0] {
      IMD_MOD_OFF,
      IMD_MOD_HALF,
      IMD_MOD_QUARTER,
      IMD_MOD_EIGHTH
   } imd_mod_e_t;

   typedef struct packed {
      imd_interp_e_t interp;
      imd_mod_e_t    modsel;
      logic          stuff;
      logic          cplx;
      logic          rot_pos;
      logic          rsv;
   } imd_ctrl_t;

   typedef struct packed {
      logic [15:0] i;
      logic [15:0] q;
   } imd_iq_t;

   typedef struct packed {
      logic [15:0] prev;
      logic [15:0] curr;
      logic [15:0] out;
   } imd_itp_st_t;

   typedef struct packed {
      logic [15:0] sin_v;
      logic [15:0] cos_v;
   } imd_car_st_t;

endpackage

// ===== rtl/imd_interp.sv
/*
 One channel of the interpolator: linear interpolation between the last two
 input samples, phase k of L, with L a power of two given as a shift.
 Assumes load comes on the last phase of each input period.
*/
module imd_interp (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // Control
   input  wire logic        load,
   input  wire logic [2:0]  k,
   input  wire logic [1:0]  shift,
   // Samples
   input  wire logic [15:0] sample_in,
   output logic      [15:0] sample_out
);
   import imd_pkg::*;

   imd_itp_st_t      st;
   imd_itp_st_t      next_st;
   logic signed [16:0] diff;
   logic signed [20:0] prod;
   logic signed [20:0] sum;

   always_comb begin
      next_st = st;
      diff = $signed({st.curr[15], st.curr}) - $signed({st.prev[15], st.prev});
      prod = diff * $signed({1'b0, k});
      sum  = (prod >>> shift) + $signed({{5{st.prev[15]}}, st.prev});
      next_st.out = sum[15:0];
      if (load) begin
         next_st.prev = st.curr;
         next_st.curr = sample_in;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign sample_out = st.out;
endmodule

// ===== rtl/imd_carrier.sv
/*
 Carrier table: registered sine and cosine of an eight-step phase, Q2.14.
 Assumes the phase advances once per interpolated sample.
*/
`include "imd_params.svh"
module imd_carrier (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // Phase in, carrier out
   input  wire logic [2:0]  phase,
   output logic      [15:0] sin_out,
   output logic      [15:0] cos_out
);
   import imd_pkg::*;

   imd_car_st_t st;
   imd_car_st_t next_st;

   function automatic logic [15:0] sine8(input logic [2:0] p);
      logic [15:0] v;
      case (p)
         3'h0:    v = 16'h0000;
         3'h1:    v = `IMD_CAR_R2;
         3'h2:    v = `IMD_CAR_ONE;
         3'h3:    v = `IMD_CAR_R2;
         3'h4:    v = 16'h0000;
         3'h5:    v = 16'h0000 - `IMD_CAR_R2;
         3'h6:    v = 16'h0000 - `IMD_CAR_ONE;
         default: v = 16'h0000 - `IMD_CAR_R2;
      endcase
      return v;
   endfunction

   always_comb begin
      next_st = st;
      next_st.sin_v = sine8(phase);
      next_st.cos_v = sine8(phase + 3'h2);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign sin_out = st.sin_v;
   assign cos_out = st.cos_v;
endmodule

// ===== rtl/imd_datapath.sv
/*
 Dual channel transmit datapath: interpolation by 1, 2, 4 or 8, real or
 complex digital modulation, optional zero stuffing, APB control.
 Assumes pclk is the converter sample clock: one DAC word per cycle, and
 an upstream source that offers I/Q pairs under valid/ready.
*/
`include "imd_params.svh"

////////////////////////////////////////////////////////////////////////////
module imd_datapath (
   // APB slave
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [11:0]      paddr,
   input  wire logic [31:0]      pwdata,
   output logic      [31:0]      prdata,
   output logic                  pready,
   output logic                  pslverr,
   // Upstream sample source
   input  wire imd_pkg::imd_iq_t in_sample,
   input  wire logic             in_valid,
   output logic                  in_ready,
   // Converter words, offset binary
   output logic      [15:0]      dac_i,
   output logic      [15:0]      dac_q,
   output logic                  dac_valid
);
   import imd_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // State

   typedef struct packed {
      imd_ctrl_t   ctrl;
      logic        underrun;
      logic [31:0] rdata;
      logic        rerr;
      logic [3:0]  slot;
      logic [2:0]  phase;
      logic        stuff_d;
      logic        cplx_d;
      imd_mod_e_t  mod_d;
      logic        rot_d;
      logic [15:0] out_i;
      logic [15:0] out_q;
      logic        out_valid;
   } imd_st_t;

   imd_st_t st;
   imd_st_t next_st;

   ////////////////////////////////////////////////////////////////////////
   // Rate control signals

   logic [1:0]  shift;
   logic [3:0]  last_slot;
   logic        stuff_slot;
   logic [2:0]  k;
   logic        load;
   logic [2:0]  phase_step;
   logic        cplx_act;
   imd_iq_t     feed;
   logic [15:0] itp_i;
   logic [15:0] itp_q;
   logic [15:0] car_sin;
   logic [15:0] car_cos;

   always_comb begin
      shift = st.ctrl.interp;
      // Last slot of one input period
      case (st.ctrl.interp)
         IMD_INTERP_2X: last_slot = 4'h1;
         IMD_INTERP_4X: last_slot = 4'h3;
         IMD_INTERP_8X: last_slot = 4'h7;
         default:       last_slot = 4'h0;
      endcase
      // Twice as many slots when stuffing
      if (st.ctrl.stuff) begin
         last_slot = {last_slot[2:0], 1'b1};
      end
      stuff_slot = st.ctrl.stuff & st.slot[0];
      if (st.ctrl.stuff) begin
         k = st.slot[3:1];
      end else begin
         k = st.slot[2:0];
      end
      load = (st.slot >= last_slot);
      case (st.ctrl.modsel)
         IMD_MOD_HALF:    phase_step = 3'h4;
         IMD_MOD_QUARTER: phase_step = 3'h2;
         IMD_MOD_EIGHTH:  phase_step = 3'h1;
         default:         phase_step = 3'h0;
      endcase
      // Complex only with quadrature carriers
      cplx_act = st.ctrl.cplx &
                 ((st.ctrl.modsel == IMD_MOD_QUARTER) |
                  (st.ctrl.modsel == IMD_MOD_EIGHTH));
      if (in_valid) begin
         feed = in_sample;
      end else begin
         feed = '0;
      end
   end

   assign in_ready = load;

   ////////////////////////////////////////////////////////////////////////
   // Interpolators, one per channel, ahead of the modulator

   for (genvar ch = 0; ch < 2; ch++) begin : g_chan
      logic [15:0] ch_in;
      logic [15:0] ch_out;
      assign ch_in = (ch == 0) ? feed.i : feed.q;
      imd_interp u_interp (
         .pclk       (pclk),
         .presetn    (presetn),
         .load       (load),
         .k          (k),
         .shift      (shift),
         .sample_in  (ch_in),
         .sample_out (ch_out)
      );
   end

   assign itp_i = g_chan[0].ch_out;
   assign itp_q = g_chan[1].ch_out;

   ////////////////////////////////////////////////////////////////////////
   // Carrier

   imd_carrier u_carrier (
      .pclk    (pclk),
      .presetn (presetn),
      .phase   (st.phase),
      .sin_out (car_sin),
      .cos_out (car_cos)
   );

   ////////////////////////////////////////////////////////////////////////
   // Modulator arithmetic

   // Drop the carrier fraction, clip to sixteen bits
   function automatic logic [15:0] sat16(input logic signed [33:0] v);
      logic signed [33:0] s;
      logic [15:0]        r;
      s = v >>> `IMD_CAR_FRAC;
      if (s > 34'sh0_0000_7FFF) begin
         r = 16'h7FFF;
      end else if (s < -34'sh0_0000_8000) begin
         r = 16'h8000;
      end else begin
         r = s[15:0];
      end
      return r;
   endfunction

   logic signed [31:0] p_ic;
   logic signed [31:0] p_is;
   logic signed [31:0] p_qc;
   logic signed [31:0] p_qs;
   logic signed [33:0] acc_i;
   logic signed [33:0] acc_q;
   logic [15:0]        mod_i;
   logic [15:0]        mod_q;

   always_comb begin
      p_ic = $signed(itp_i) * $signed(car_cos);
      p_is = $signed(itp_i) * $signed(car_sin);
      p_qc = $signed(itp_q) * $signed(car_cos);
      p_qs = $signed(itp_q) * $signed(car_sin);
      acc_i = 34'(p_ic);
      acc_q = 34'(p_qc);
      if (st.cplx_d) begin
         if (st.rot_d) begin
            acc_i = 34'(p_ic) - 34'(p_qs);
            acc_q = 34'(p_qc) + 34'(p_is);
         end else begin
            acc_i = 34'(p_ic) + 34'(p_qs);
            acc_q = 34'(p_qc) - 34'(p_is);
         end
         mod_i = sat16(acc_i);
         mod_q = sat16(acc_q);
      end else begin
         case (st.mod_d)
            IMD_MOD_HALF: begin
               mod_i = sat16(34'(p_ic));
               mod_q = sat16(34'(p_qc));
            end
            IMD_MOD_QUARTER, IMD_MOD_EIGHTH: begin
               mod_i = sat16(34'(p_is));
               mod_q = sat16(34'(p_qs));
            end
            default: begin
               mod_i = itp_i;
               mod_q = itp_q;
            end
         endcase
      end
   end

   // Two's complement to offset binary for the converter
   function automatic logic [15:0] to_ofs(input logic [15:0] v);
      logic [15:0] r;
      r = {~v[15], v[14:0]};
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Next state

   logic setup;
   logic access;
   logic hit_ctrl;
   logic hit_status;
   logic ctrl_wr;
   logic underrun_set;
   logic underrun_clr;

   always_comb begin
      next_st = st;
      setup  = psel & ~penable;
      access = psel & penable;
      hit_ctrl   = (paddr == `IMD_CTRL_ADDR);
      hit_status = (paddr == `IMD_STATUS_ADDR);
      ctrl_wr    = access & pwrite & hit_ctrl;

      // Sample timing
      if (load) begin
         next_st.slot = 4'h0;
      end else begin
         next_st.slot = st.slot + 4'h1;
      end
      if (!stuff_slot) begin
         next_st.phase = st.phase + phase_step;
      end
      // Control write starts a fresh period at carrier phase zero
      if (ctrl_wr) begin
         next_st.slot  = 4'h0;
         next_st.phase = 3'h0;
      end
      next_st.stuff_d = stuff_slot;
      next_st.cplx_d  = cplx_act;
      // Mode bits follow the carrier through its register
      next_st.mod_d   = st.ctrl.modsel;
      next_st.rot_d   = st.ctrl.rot_pos;

      // Output stage, midscale in stuffed slots
      if (st.stuff_d) begin
         next_st.out_i = `IMD_MIDSCALE;
         next_st.out_q = `IMD_MIDSCALE;
      end else begin
         next_st.out_i = to_ofs(mod_i);
         next_st.out_q = to_ofs(mod_q);
      end
      next_st.out_valid = 1'b1;

      // Underrun: set wins over clear
      underrun_set = load & ~in_valid;
      underrun_clr = access & pwrite & hit_status &
                     pwdata[`IMD_S_UNDERRUN];
      next_st.underrun = underrun_set | (st.underrun & ~underrun_clr);

      // Register reads captured in setup
      if (setup) begin
         next_st.rdata = 32'h0000_0000;
         next_st.rerr  = 1'b0;
         if (hit_ctrl) begin
            next_st.rdata[7:0] = st.ctrl;
         end else if (hit_status) begin
            next_st.rdata[`IMD_S_UNDERRUN] = st.underrun;
            next_st.rdata[`IMD_S_PHASE_LO +: 3] = st.phase;
            next_st.rdata[`IMD_S_SLOT_LO +: 4]  = st.slot;
            next_st.rdata[`IMD_S_CPLX_ACT] = cplx_act;
         end else begin
            next_st.rerr = 1'b1;
         end
      end

      // Control write at the access edge
      if (ctrl_wr) begin
         next_st.ctrl.interp = imd_interp_e_t'(
            pwdata[`IMD_F_INTERP_HI:`IMD_F_INTERP_LO]);
         next_st.ctrl.modsel = imd_mod_e_t'(
            pwdata[`IMD_F_MOD_HI:`IMD_F_MOD_LO]);
         next_st.ctrl.stuff   = pwdata[`IMD_F_STUFF];
         next_st.ctrl.cplx    = pwdata[`IMD_F_CPLX];
         next_st.ctrl.rot_pos = pwdata[`IMD_F_ROTPOS];
         next_st.ctrl.rsv     = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st      <= '0;
         st.ctrl <= imd_ctrl_t'(`IMD_CTRL_RESET);
         st.out_i <= `IMD_MIDSCALE;
         st.out_q <= `IMD_MIDSCALE;
      end else begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs

   assign prdata    = st.rdata;
   assign pslverr   = st.rerr & psel & penable;
   assign pready    = 1'b1;
   assign dac_i     = st.out_i;
   assign dac_q     = st.out_q;
   assign dac_valid = st.out_valid;
endmodule

// ===== bench/imd_monitor.sv
/*
 Port checker of the datapath: APB decode, control readback, input rate,
 zero stuffing and valid after reset.
 Assumes binding to imd_datapath by the statement at the foot.
*/
module imd_monitor (
   // Clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // APB
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Stream
   input wire logic        in_ready,
   input wire logic [15:0] dac_i,
   input wire logic [15:0] dac_q,
   input wire logic        dac_valid
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] ctrl;
   logic [5:0] since;
   logic [5:0] gap;
   logic [4:0] per;
   logic       acc;
   logic       bad;

   assign acc = psel && penable;
   assign bad = paddr != 12'h004 && paddr != 12'h07C;
   assign per = (5'h01 << ctrl[7:6]) << ctrl[3];

   ////////////////////////////////////////////////////////////////////////
   // Shadow of control, cycles since its write, gap between input pulses
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl  <= 8'h00;
         since <= 6'h00;
         gap   <= 6'h00;
      end else begin
         if (acc && pwrite && paddr == 12'h004) begin
            ctrl  <= pwdata[7:0] & 8'hFE;
            since <= 6'h00;
         end else if (since != 6'h3F) begin
            since <= since + 6'h01;
         end
         gap <= in_ready ? 6'h01 : gap + 6'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   ready_high_a:
   assert property (pready) else $error("pready low");
   err_phase_a:
   assert property (pslverr |-> acc) else $error("pslverr outside access");
   err_decode_a:
   assert property (acc |-> pslverr == bad) else $error("decode wrong");
   unmapped_zero_a:
   assert property (acc && !pwrite && bad |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   ctrl_read_a:
   assert property (acc && !pwrite && paddr == 12'h004
      |-> prdata == {24'h0, ctrl}) else $error("control readback wrong");
   valid_run_a:
   assert property ($past(presetn) |-> dac_valid)
      else $error("dac_valid low after reset");
   stuff_mid_a:
   assert property (since > 6'h28 && ctrl[3]
      |-> {dac_i, dac_q} == 32'h80008000
      || $past({dac_i, dac_q}) == 32'h80008000)
      else $error("no midscale word between samples");
   input_rate_a:
   assert property (since > 6'h28 && in_ready |-> gap == {1'b0, per})
      else $error("input period wrong");
endmodule

bind imd_datapath imd_monitor u_mon (.pclk, .presetn, .psel, .penable,
   .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .in_ready,
   .dac_i, .dac_q, .dac_valid);

// ===== bench/imd_source.sv
/*
 Upstream sample source: offers one I/Q pair each cycle, may stall.
 Assumes the bench changes value and stall just after a rising edge.
*/
module imd_source (
   // Clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   // Control from bench
   input  wire logic             stall,
   input  wire imd_pkg::imd_iq_t value,
   // Stream to datapath
   output imd_pkg::imd_iq_t      in_sample,
   output logic                  in_valid
);
   timeunit 1ns;
   timeprecision 1ps;
   import imd_pkg::*;

   // Stalled data toggles so stale values never look valid
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         in_sample <= '0;
         in_valid  <= 1'b0;
      end else begin
         in_valid  <= !stall;
         in_sample <= stall ? ~in_sample : value;
      end
   end
endmodule

// ===== bench/tb_top.sv
/*
 Self-checking bench of the datapath: every control setting with random
 samples, carrier sequences, stuffing, complex mix, decode and underrun.
 Assumes rtl/ on the include path and the checker bound by its own file.
*/
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import imd_pkg::*;

   localparam logic [15:0] sin_tab [8] = '{16'h0000, 16'h2D41, 16'h4000,
      16'h2D41, 16'h0000, 16'hD2BF, 16'hC000, 16'hD2BF};

   logic        pclk    = 1'b0;
   logic        presetn = 1'b0;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic        stall   = 1'b0;
   logic [11:0] paddr   = 12'h000;
   logic [31:0] pwdata  = 32'h0;
   logic [31:0] prdata;
   logic [31:0] rd;
   logic        pready;
   logic        pslverr;
   logic        err;
   logic        in_valid;
   logic        in_ready;
   logic        dac_valid;
   imd_iq_t     value   = '0;
   imd_iq_t     in_sample;
   logic [15:0] dac_i;
   logic [15:0] dac_q;
   logic [31:0] got [32];
   int          miscompares  = 0;
   int          total_checks = 0;
   int          seed         = 32'h3F64;

   always #2.5 pclk = ~pclk;

   imd_datapath u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .in_sample, .in_valid,
      .in_ready, .dac_i, .dac_q, .dac_valid);
   imd_source u_src (.pclk, .presetn, .stall, .value, .in_sample,
      .in_valid);

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e) begin
         miscompares++;
         $display("CHECK FAILED %0t got %h expected %h", $time, g, e);
      end
   endtask

   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 100);
      if (n == 100) miscompares++;
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   function automatic logic [15:0] rnd();
      logic [31:0] r;
      r = $random(seed);
      return {{3{r[12]}}, r[12:0]};
   endfunction

   // Sum of two Q2.14 products, fraction dropped after the sum
   function automatic logic [15:0] mac(input logic [15:0] a,
                                       input logic [15:0] b,
                                       input logic [15:0] c,
                                       input logic [15:0] d);
      logic signed [31:0] p;
      logic signed [31:0] q;
      logic signed [33:0] t;
      p = $signed(a) * $signed(b);
      q = $signed(c) * $signed(d);
      t = p + q;
      return t[29:14];
   endfunction

   // Expected converter pair at slot k of one carrier period
   function automatic logic [31:0] expw(input logic [7:0] c,
                                        input imd_iq_t s, input int k);
      int          ph;
      logic [15:0] sn;
      logic [15:0] cs;
      logic [15:0] i;
      logic [15:0] q;
      if (c[3] && k % 2 == 1) return 32'h80008000;
      ph = (c[3] ? k / 2 : k) * (8 >> c[5:4]);
      sn = sin_tab[ph % 8];
      cs = sin_tab[(ph + 2) % 8];
      if (c[5:4] == 2'b00) begin
         i = s.i;
         q = s.q;
      end else if (c[2] && c[5]) begin
         if (!c[1]) sn = -sn;
         i = mac(s.i, cs, s.q, -sn);
         q = mac(s.q, cs, s.i, sn);
      end else begin
         if (c[5:4] == 2'b01) sn = cs;
         i = mac(s.i, sn, 16'h0000, 16'h0000);
         q = mac(s.q, sn, 16'h0000, 16'h0000);
      end
      return {i ^ 16'h8000, q ^ 16'h8000};
   endfunction

   task automatic run(input logic [7:0] c);
      imd_iq_t s;
      logic    ok;
      logic    hit;
      s.i = rnd();
      s.q = rnd();
      value <= s;
      apb(1'b1, 12'h004, {24'h0, c | 8'(seed[0])});
      apb(1'b0, 12'h004, 32'h0);
      chk(rd, {24'h0, c});
      repeat (48) @(posedge pclk);
      for (int n = 0; n < 32; n++) begin
         @(negedge pclk);
         got[n] = {dac_i, dac_q};
      end
      ok = 1'b0;
      for (int r = 0; r < 16; r++) begin
         hit = 1'b1;
         for (int n = 0; n < 32; n++)
            if (got[n] !== expw(c, s, (n + r) % 16)) hit = 1'b0;
         if (hit) ok = 1'b1;
      end
      chk({31'h0, ok}, 32'h1);
      @(posedge pclk);
   endtask

   task automatic summarize;
      $display("Checks %0d, mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b1, 12'h07C, 32'h1);
      for (int c = 0; c < 256; c += 2) run(8'(c));
      apb(1'b1, 12'h008, 32'hFFFFFFFF);
      chk({31'h0, err}, 32'h1);
      apb(1'b0, 12'h008, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 12'h004, 32'h0);
      chk(rd, 32'hFE);
      apb(1'b1, 12'h004, 32'h0);
      stall <= 1'b1;
      repeat (40) @(negedge pclk);
      chk({dac_i, dac_q}, 32'h80008000);
      @(posedge pclk);
      apb(1'b0, 12'h07C, 32'h0);
      chk({31'h0, rd[0]}, 32'h1);
      stall <= 1'b0;
      repeat (4) @(posedge pclk);
      apb(1'b1, 12'h07C, 32'h1);
      apb(1'b0, 12'h07C, 32'h0);
      chk({31'h0, rd[0]}, 32'h0);
      // Reset in mid run: outputs park, control returns to zero
      apb(1'b1, 12'h004, 32'hFE);
      presetn <= 1'b0;
      repeat (3) @(negedge pclk);
      chk({dac_i, dac_q}, 32'h80008000);
      chk({31'h0, dac_valid}, 32'h0);
      @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, 12'h004, 32'h0);
      chk(rd, 32'h0);
      chk({31'h0, dac_valid}, 32'h1);
      summarize;
   end

   initial begin
      #100000;
      miscompares++;
      summarize;
   end
endmodule
